// ===== hw/bst_map.vh
// Constants for the boundary-scan test access port.
// Assumes inclusion by the port's design file and by the bench.
`ifndef BST_MAP_VH
`define BST_MAP_VH

// ==========================================================
// Instruction register
`define BST_IR_W 4
`define BST_IR_EXTEST 4'h0
`define BST_IR_IDCODE 4'h1
`define BST_IR_SAMPLE 4'h2
`define BST_IR_HIGHZ 4'h5
`define BST_IR_BYPASS 4'hF
`define BST_IR_CAPTURE 4'h1
`define BST_IR_RESET `BST_IR_IDCODE

// ==========================================================
// Identification register
`define BST_ID_W 32
// Arbitrary neutral value; bit 0 set as the identity marker
`define BST_ID_VALUE 32'h0A5A_0001

// ==========================================================
// Test pin positions in the four-pin groups
`define BST_PIN_TCK 0
`define BST_PIN_TMS 1
`define BST_PIN_TDI 2
`define BST_PIN_TDO 3

// ==========================================================
// Boundary register layout, per system pin N
// Out data at [N-1:0], enable at [2N-1:N], input at [3N-1:2N]
`define BST_BSR_GROUPS 3

`endif

// ===== hw/bst_sync.v
// Two-flop synchroniser for a group of pin inputs.
// Assumes inputs are asynchronous to sys_clk.
`timescale 1ns/1ps
`default_nettype none

module bst_sync #(
  parameter W = 4
) (
  // Clock and reset
  input wire sys_clk,
  input wire rst,
  // Pins in, synchronised out
  input wire [W-1:0] async_in,
  output reg [W-1:0] sync_out
);

  reg [W-1:0] meta;

  // ==========================================================
  // Only the second flop reads the first
  always @(posedge sys_clk) begin
    if (rst) begin
      meta <= {W{1'b0}};
      sync_out <= {W{1'b0}};
    end else begin
      meta <= async_in;
      sync_out <= meta;
    end
  end

endmodule // bst_sync

`default_nettype wire

// ===== hw/bst_bsr.v
// Boundary-scan shift register with capture stage and update latches.
// Assumes one-cycle capture, shift and update strobes from the port.
`timescale 1ns/1ps
`default_nettype none

module bst_bsr #(
  parameter LEN = 24
) (
  // Clock and reset
  input wire sys_clk,
  input wire rst,
  // Strobes and serial data
  input wire capture,
  input wire shift,
  input wire update,
  input wire ser_in,
  output wire ser_out,
  // Parallel side
  input wire [LEN-1:0] cap_data,
  output reg [LEN-1:0] upd_data
);

  reg [LEN-1:0] sh;

  assign ser_out = sh[0];

  // ==========================================================
  // One cell per bit; serial data enters at the top
  genvar i;
  generate
    for (i = 0; i < LEN; i = i + 1) begin : g_cell
      always @(posedge sys_clk) begin
        if (rst) begin
          sh[i] <= 1'b0;
          upd_data[i] <= 1'b0;
        end else begin
          if (capture) begin
            sh[i] <= cap_data[i];
          end else if (shift) begin
            sh[i] <= (i == LEN - 1) ? ser_in : sh[(i + 1) % LEN];
          end
          // Latches hold while shifting so the pins never ripple
          if (update) begin
            upd_data[i] <= sh[i];
          end
        end
      end
    end
  endgenerate

endmodule // bst_bsr

`default_nettype wire

// ===== hw/bst_tap_port.v
// Boundary-scan test access port with four-wire serial link.
// Assumes the test clock is far slower than sys_clk (125 ns vs 10 ns),
// rst is the power-up reset, test_sel is a static configuration bit.
`timescale 1ns/1ps
`default_nettype none
`include "bst_map.vh"

// How it works
// - Only clock, mode, data in, data out pins; no test-reset input.
// - Power-up reset puts the test logic into its reset state.
// - Data-in is sampled on the rising test-clock edge.
// - Data-out changes on the falling test-clock edge.
// - Data-out floats unless a shift state is active.
// - The controller moves only on test-clock edges.
// - Code 0010 samples pins and core, and preloads the boundary latches.
// - Code 0000 drives the pins from the boundary latches.
// - Code 1111 puts a one-bit bypass stage between data-in and data-out.
// - Shifting all ones into the instruction register yields bypass.
// - Code 0001 shifts out the identification register.
// - Code 0101 floats every system output while active.
// - Code 0101 routes serial data through the bypass stage.
// - With the test function off, the four pins are ordinary I/O.
// - Macrocells behind the test pins stay usable as buried logic.
module bst_tap_port #(
  parameter N_IO = 8,
  parameter [`BST_ID_W-1:0] ID_VALUE = `BST_ID_VALUE
) (
  // Clock and power-up reset
  input wire sys_clk,
  input wire rst,
  // Configuration: test function selected
  input wire test_sel,
  // Four test pins, each as in, out, enable (low drives)
  input wire [3:0] tpin_in,
  output reg [3:0] tpin_out,
  output reg [3:0] tpin_oe_n,
  // Core side of the four test-pin macrocells
  input wire [3:0] gpio_out,
  input wire [3:0] gpio_oe,
  output reg [3:0] gpio_in,
  output reg [3:0] buried_fb,
  // System pins
  input wire [N_IO-1:0] pin_in,
  output reg [N_IO-1:0] pin_out,
  output reg [N_IO-1:0] pin_oe_n,
  // Core side of the system pins
  input wire [N_IO-1:0] core_out,
  input wire [N_IO-1:0] core_oe,
  output reg [N_IO-1:0] core_in,
  // Controller status
  output reg test_reset_st
);

  localparam BSR_LEN = `BST_BSR_GROUPS * N_IO;

  // ==========================================================
  // Controller states, one-hot
  localparam [15:0] S_TLR = 16'h0001;
  localparam [15:0] S_RTI = 16'h0002;
  localparam [15:0] S_SEL_DR = 16'h0004;
  localparam [15:0] S_CAP_DR = 16'h0008;
  localparam [15:0] S_SH_DR = 16'h0010;
  localparam [15:0] S_EX1_DR = 16'h0020;
  localparam [15:0] S_PA_DR = 16'h0040;
  localparam [15:0] S_EX2_DR = 16'h0080;
  localparam [15:0] S_UP_DR = 16'h0100;
  localparam [15:0] S_SEL_IR = 16'h0200;
  localparam [15:0] S_CAP_IR = 16'h0400;
  localparam [15:0] S_SH_IR = 16'h0800;
  localparam [15:0] S_EX1_IR = 16'h1000;
  localparam [15:0] S_PA_IR = 16'h2000;
  localparam [15:0] S_EX2_IR = 16'h4000;
  localparam [15:0] S_UP_IR = 16'h8000;

  // ==========================================================
  // Pin synchronisers
  wire [3:0] tpin_s;
  wire [N_IO-1:0] pin_s;

  bst_sync #(.W(4)) u_tsync (
    .sys_clk(sys_clk),
    .rst(rst),
    .async_in(tpin_in),
    .sync_out(tpin_s)
  );

  bst_sync #(.W(N_IO)) u_psync (
    .sys_clk(sys_clk),
    .rst(rst),
    .async_in(pin_in),
    .sync_out(pin_s)
  );

  // ==========================================================
  // Test-clock edge detection
  reg test_mode;
  reg tck_d;
  wire tck_s = tpin_s[`BST_PIN_TCK];
  wire tms_s = tpin_s[`BST_PIN_TMS];
  wire tdi_s = tpin_s[`BST_PIN_TDI];
  // Edges only count in test mode, so GPIO traffic cannot move the controller
  wire tck_rise = test_mode & tck_s & ~tck_d;
  wire tck_fall = test_mode & ~tck_s & tck_d;

  always @(posedge sys_clk) begin
    if (rst) begin
      tck_d <= 1'b0;
      // Configuration caught while in reset, held until the next one
      test_mode <= test_sel;
    end else begin
      tck_d <= tck_s;
    end
  end

  // ==========================================================
  // Controller state machine
  reg [15:0] state;
  reg [15:0] next_state;

  always @* begin
    case (state)
      S_TLR: next_state = tms_s ? S_TLR : S_RTI;
      S_RTI: next_state = tms_s ? S_SEL_DR : S_RTI;
      S_SEL_DR: next_state = tms_s ? S_SEL_IR : S_CAP_DR;
      S_CAP_DR: next_state = tms_s ? S_EX1_DR : S_SH_DR;
      S_SH_DR: next_state = tms_s ? S_EX1_DR : S_SH_DR;
      S_EX1_DR: next_state = tms_s ? S_UP_DR : S_PA_DR;
      S_PA_DR: next_state = tms_s ? S_EX2_DR : S_PA_DR;
      S_EX2_DR: next_state = tms_s ? S_UP_DR : S_SH_DR;
      S_UP_DR: next_state = tms_s ? S_SEL_DR : S_RTI;
      S_SEL_IR: next_state = tms_s ? S_TLR : S_CAP_IR;
      S_CAP_IR: next_state = tms_s ? S_EX1_IR : S_SH_IR;
      S_SH_IR: next_state = tms_s ? S_EX1_IR : S_SH_IR;
      S_EX1_IR: next_state = tms_s ? S_UP_IR : S_PA_IR;
      S_PA_IR: next_state = tms_s ? S_EX2_IR : S_PA_IR;
      S_EX2_IR: next_state = tms_s ? S_UP_IR : S_SH_IR;
      S_UP_IR: next_state = tms_s ? S_SEL_DR : S_RTI;
      default: next_state = S_TLR;
    endcase
  end

  // No reset pin: power-up reset is the only asynchronous way home
  always @(posedge sys_clk) begin
    if (rst) begin
      state <= S_TLR;
    end else if (tck_rise) begin
      state <= next_state;
    end
  end

  // ==========================================================
  // Instruction register and decode
  reg [`BST_IR_W-1:0] ir;
  reg [`BST_IR_W-1:0] ir_sh;
  wire sel_bsr = (ir == `BST_IR_SAMPLE) | (ir == `BST_IR_EXTEST);
  wire sel_id = (ir == `BST_IR_IDCODE);
  // Everything else, highz and unlisted codes included, lands on bypass
  wire sel_byp = ~sel_bsr & ~sel_id;
  wire extest = (ir == `BST_IR_EXTEST);
  wire highz = (ir == `BST_IR_HIGHZ);

  always @(posedge sys_clk) begin
    if (rst) begin
      ir <= `BST_IR_RESET;
      ir_sh <= {`BST_IR_W{1'b0}};
    end else if (tck_rise) begin
      if (state == S_TLR) begin
        ir <= `BST_IR_RESET;
      end
      if (state == S_CAP_IR) begin
        ir_sh <= `BST_IR_CAPTURE;
      end else if (state == S_SH_IR) begin
        ir_sh <= {tdi_s, ir_sh[`BST_IR_W-1:1]};
      end
    end else if (tck_fall && state == S_UP_IR) begin
      ir <= ir_sh;
    end
  end

  // ==========================================================
  // Bypass and identification registers
  reg byp;
  reg [`BST_ID_W-1:0] id_sh;

  always @(posedge sys_clk) begin
    if (rst) begin
      byp <= 1'b0;
      id_sh <= {`BST_ID_W{1'b0}};
    end else if (tck_rise) begin
      if (state == S_CAP_DR) begin
        byp <= 1'b0;
        id_sh <= ID_VALUE;
      end else if (state == S_SH_DR) begin
        // One stage: a bit in at this edge leaves at the next fall
        byp <= tdi_s;
        id_sh <= {tdi_s, id_sh[`BST_ID_W-1:1]};
      end
    end
  end

  // ==========================================================
  // Boundary register
  wire bsr_so;
  wire [BSR_LEN-1:0] bsr_upd;
  wire [BSR_LEN-1:0] bsr_cap = {pin_s, core_oe, core_out};

  bst_bsr #(.LEN(BSR_LEN)) u_bsr (
    .sys_clk(sys_clk),
    .rst(rst),
    .capture(tck_rise & sel_bsr & (state == S_CAP_DR)),
    .shift(tck_rise & sel_bsr & (state == S_SH_DR)),
    .update(tck_fall & sel_bsr & (state == S_UP_DR)),
    .ser_in(tdi_s),
    .ser_out(bsr_so),
    .cap_data(bsr_cap),
    .upd_data(bsr_upd)
  );

  // ==========================================================
  // Serial output, changed on the falling test-clock edge
  reg tdo_q;
  reg tdo_en;
  wire dr_so = sel_bsr ? bsr_so : (sel_id ? id_sh[0] : byp);

  always @(posedge sys_clk) begin
    if (rst) begin
      tdo_q <= 1'b0;
      tdo_en <= 1'b0;
    end else if (tck_fall) begin
      if (state == S_SH_IR) begin
        tdo_q <= ir_sh[0];
        tdo_en <= 1'b1;
      end else if (state == S_SH_DR) begin
        tdo_q <= dr_so;
        tdo_en <= 1'b1;
      end else begin
        tdo_en <= 1'b0;
      end
    end
  end

  // ==========================================================
  // Test pins: serial link or general I/O
  integer k;

  always @(posedge sys_clk) begin
    if (rst) begin
      tpin_out <= 4'h0;
      tpin_oe_n <= 4'hF;
      gpio_in <= 4'h0;
      buried_fb <= 4'h0;
      test_reset_st <= 1'b1;
    end else begin
      gpio_in <= test_mode ? 4'h0 : tpin_s;
      // Macrocell logic keeps feeding the core even when pins are taken
      buried_fb <= gpio_out;
      test_reset_st <= (state == S_TLR);
      for (k = 0; k < 4; k = k + 1) begin
        if (!test_mode) begin
          tpin_out[k] <= gpio_out[k];
          tpin_oe_n[k] <= ~gpio_oe[k];
        end else if (k == `BST_PIN_TDO) begin
          tpin_out[k] <= tdo_q;
          tpin_oe_n[k] <= ~tdo_en;
        end else begin
          tpin_out[k] <= 1'b0;
          tpin_oe_n[k] <= 1'b1;
        end
      end
    end
  end

  // ==========================================================
  // System pins: core, boundary latches, or floated
  always @(posedge sys_clk) begin
    if (rst) begin
      pin_out <= {N_IO{1'b0}};
      pin_oe_n <= {N_IO{1'b1}};
      core_in <= {N_IO{1'b0}};
    end else begin
      core_in <= pin_s;
      if (test_mode && highz) begin
        pin_out <= core_out;
        pin_oe_n <= {N_IO{1'b1}};
      end else if (test_mode && extest) begin
        pin_out <= bsr_upd[N_IO-1:0];
        pin_oe_n <= ~bsr_upd[2*N_IO-1:N_IO];
      end else begin
        // Sample, bypass and idcode leave normal operation untouched
        pin_out <= core_out;
        pin_oe_n <= ~core_oe;
      end
    end
  end

endmodule // bst_tap_port

`default_nettype wire

// ===== tb/bst_tap_port_asserts.sv
// Checker for the boundary-scan port, bound to its top module.
// Assumes tpin_in bit 0 is the raw test clock, slow against sys_clk.
`timescale 1ns/1ps
`default_nettype none

module bst_tap_chk (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic test_sel,
  // Test pins
  input wire logic [3:0] tpin_in,
  input wire logic [3:0] tpin_out,
  input wire logic [3:0] tpin_oe_n,
  input wire logic [3:0] gpio_out,
  input wire logic [3:0] gpio_oe,
  input wire logic [3:0] gpio_in,
  input wire logic [3:0] buried_fb,
  input wire logic test_reset_st
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  // Configuration is only taken during reset
  logic sel_q;
  always @(posedge sys_clk) begin
    if (rst) begin
      sel_q <= test_sel;
    end
  end

  // ==========================================================
  // Assertions
  chk_reset_idle: assert property (@(posedge sys_clk) disable iff (1'b0)
    rst |=> tpin_oe_n == 4'hF && test_reset_st) else $error("reset not idle");
  chk_only_tdo: assert property (sel_q |-> tpin_oe_n[2:0] == 3'h7)
    else $error("test pin other than data-out driven");
  chk_gpio_zero: assert property (sel_q |-> gpio_in == 4'h0)
    else $error("gpio input seen in test mode");
  chk_test_off: assert property (!sel_q |-> test_reset_st)
    else $error("controller moved with test off");
  chk_buried_fb: assert property (!$past(rst) |-> buried_fb == $past(gpio_out))
    else $error("buried feedback lost");
  chk_gpio_drive: assert property ((!sel_q && !$past(rst)) |->
    tpin_out == $past(gpio_out) && tpin_oe_n == ~$past(gpio_oe)) else $error("gpio drive wrong");
  chk_tdo_fall: assert property ((sel_q && !$past(rst) && $changed(tpin_out[3]))
    |-> !$past(tpin_in[0], 3)) else $error("data-out moved off the falling edge");
  chk_tdo_float: assert property ((sel_q && $fell(tpin_oe_n[3]))
    |-> !$past(tpin_in[0], 3) && !test_reset_st) else $error("data-out driven outside shift");
  chk_ctrl_tck: assert property ((!$past(rst) && $changed(test_reset_st))
    |-> $past(tpin_in[0], 3)) else $error("controller moved without test clock");

  cover property (sel_q && !tpin_oe_n[3]);
  cover property ($fell(test_reset_st));
  cover property (!sel_q && gpio_oe != 4'h0);
endmodule // bst_tap_chk

bind bst_tap_port bst_tap_chk u_chk (.sys_clk, .rst, .test_sel, .tpin_in, .tpin_out,
  .tpin_oe_n, .gpio_out, .gpio_oe, .gpio_in, .buried_fb, .test_reset_st);

`default_nettype wire

// ===== tb/bst_tester.sv
// External test controller model driving the four-wire link.
// Assumes the bench pulls data-out up when the port floats it.
`timescale 1ns/1ps
`default_nettype none

module bst_tester (
  // Link pins
  output var logic tck,
  output var logic tms,
  output var logic tdi,
  input wire logic tdo
);
  initial begin
    tck = 1'b0;
    tms = 1'b1;
    tdi = 1'b1;
  end

  // One 125 ns test clock; stands low between calls
  task automatic clk(input logic m, input logic d, output logic o);
    begin
      tms = m;
      tdi = d;
      #31.25;
      o = tdo;
      tck = 1'b1;
      #62.5;
      tck = 1'b0;
      #31.25;
    end
  endtask

  // ==========================================================
  // Scan from idle, LSB first, back to idle
  task automatic scan(input logic ir, input int n, input logic [31:0] din,
    output logic [31:0] dout);
    logic o;
    begin
      dout = 32'h0;
      clk(1'b1, 1'b1, o);
      if (ir) begin
        clk(1'b1, 1'b1, o);
      end
      clk(1'b0, 1'b1, o);
      clk(1'b0, 1'b1, o);
      for (int i = 0; i < n; i++) begin
        clk(i == n - 1, din[i], o);
        dout[i] = o;
      end
      clk(1'b1, 1'b1, o);
      clk(1'b0, 1'b1, o);
      tms = 1'b1;
    end
  endtask
endmodule // bst_tester

`default_nettype wire

// ===== tb/testbench.sv
// Self-checking bench for the boundary-scan port.
// Assumes the tester model and the bound checker.
`timescale 1ns/1ps
`default_nettype none
`include "bst_map.vh"

module testbench;
  logic sys_clk, rst, test_sel, o;
  logic [3:0] gpio_out, gpio_oe;
  logic [7:0] pin_in, core_out, core_oe;
  logic [31:0] r, d, p, seed;
  logic [3:0] codes [4];
  wire [3:0] tpin_out, tpin_oe_n, gpio_in, buried_fb;
  wire [7:0] pin_out, pin_oe_n, core_in;
  wire test_reset_st, tck, tms, tdi;
  // Pull-up on data-out; a driving macrocell wins over the tester
  wire [3:0] tpin_in = (~tpin_oe_n & tpin_out) | (tpin_oe_n & {1'b1, tdi, tms, tck});
  int err_total, checks;

  bst_tap_port #(.N_IO(8)) uut (.sys_clk(sys_clk), .rst(rst), .test_sel(test_sel),
    .tpin_in(tpin_in), .tpin_out(tpin_out), .tpin_oe_n(tpin_oe_n), .gpio_out(gpio_out),
    .gpio_oe(gpio_oe), .gpio_in(gpio_in), .buried_fb(buried_fb), .pin_in(pin_in),
    .pin_out(pin_out), .pin_oe_n(pin_oe_n), .core_out(core_out), .core_oe(core_oe),
    .core_in(core_in), .test_reset_st(test_reset_st));
  bst_tester tester (.tck(tck), .tms(tms), .tdi(tdi), .tdo(tpin_in[3]));

  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  // ==========================================================
  // Helpers
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
    begin
      checks++;
      if (got !== exp) begin
        err_total++;
        $display("CHECK FAILED %0t: %s got %h exp %h", $time, msg, got, exp);
      end
    end
  endtask

  task automatic end_sim;
    begin
      $display("checks %0d errors %0d", checks, err_total);
      if (err_total == 0 && checks > 0) begin
        $display("[ PASS ]");
      end else begin
        $display("[ FAIL ]");
      end
      $finish;
    end
  endtask

  function automatic logic [23:0] bsr_exp();
    return {pin_in, core_oe, core_out};
  endfunction

  task automatic rnd;
    begin
      @(posedge sys_clk);
      r = $random(seed);
      core_out <= r[7:0];
      core_oe <= r[15:8] | 8'h81;
      pin_in <= r[23:16];
      gpio_out <= r[27:24];
      repeat (8) @(posedge sys_clk);
    end
  endtask

  task automatic ir(input logic [3:0] code);
    begin
      tester.scan(1'b1, 4, {28'h0, code}, d);
      chk(d, 32'h1, "ir capture");
      repeat (8) @(posedge sys_clk);
    end
  endtask

  initial begin
    #300000;
    err_total++;
    end_sim;
  end

  // ==========================================================
  // Main sequence
  initial begin
    seed = 32'hB1846137;
    codes = '{`BST_IR_BYPASS, `BST_IR_HIGHZ, 4'h7, 4'hC};
    {rst, test_sel, gpio_out, gpio_oe, pin_in, core_out, core_oe} = {1'b1, 33'h0};
    repeat (12) @(posedge sys_clk);
    rst <= 1'b0;
    for (int i = 0; i < 4; i++) begin
      rnd;
      gpio_oe <= r[31:28];
      repeat (8) @(posedge sys_clk);
      chk(gpio_in, tpin_in, "gpio level");
    end
    gpio_oe <= 4'h0;
    repeat (3) tester.clk(1'b0, 1'b0, o);
    chk(test_reset_st, 32'h1, "refused");
    rst <= 1'b1;
    test_sel <= 1'b1;
    repeat (12) @(posedge sys_clk);
    rst <= 1'b0;
    rnd;
    chk({test_reset_st, tpin_oe_n}, 32'h1F, "reset idle");
    tester.clk(1'b0, 1'b1, o);
    chk(test_reset_st, 32'h0, "left reset");
    tester.scan(1'b0, 32, r, d);
    chk(d, `BST_ID_VALUE, "idcode");
    for (int i = 0; i < 4; i++) begin
      rnd;
      ir(codes[i]);
      p = $random(seed);
      tester.scan(1'b0, 8, p, d);
      chk(d, {p[6:0], 1'b0}, "bypass");
      chk(core_in, pin_in, "core input");
      chk(tpin_oe_n[3], 32'h1, "tdo float");
      if (codes[i] == `BST_IR_HIGHZ) begin
        chk(pin_oe_n, 32'hFF, "highz");
      end else begin
        chk({pin_oe_n, pin_out}, {~core_oe, core_out}, "normal pins");
      end
    end
    rnd;
    ir(`BST_IR_SAMPLE);
    p = $random(seed);
    tester.scan(1'b0, 24, p, d);
    chk(d, bsr_exp(), "sample");
    chk({pin_oe_n, pin_out}, {~core_oe, core_out}, "preload quiet");
    ir(`BST_IR_EXTEST);
    chk({pin_oe_n, pin_out}, {~p[15:8], p[7:0]}, "extest");
    repeat (5) tester.clk(1'b1, 1'b1, o);
    repeat (8) @(posedge sys_clk);
    chk({test_reset_st, pin_out}, {1'b1, core_out}, "tms reset");
    end_sim;
  end
endmodule // testbench

`default_nettype wire
